// [shared/irm_regs.svh]
`ifndef IRM_REGS_SVH
`define IRM_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define IRM_OFS_IR_CTRL 5'h00
`define IRM_OFS_TMR_CTRL 5'h04
`define IRM_OFS_LO_RELOAD 5'h08
`define IRM_OFS_LO_CMP 5'h0c
`define IRM_OFS_LO_VAL 5'h10
`define IRM_OFS_HI_VAL 5'h14
`define IRM_OFS_HI_RELOAD 5'h18
`define IRM_OFS_HI_MATCH 5'h1c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IRM_IR_EN_BIT 2
`define IRM_IR_TX_BIT 1
`define IRM_IR_BB_BIT 0
`define IRM_DUAL_BIT 0
`define IRM_LO_RUN_BIT 1
`define IRM_HI_RUN_BIT 2
`define IRM_POL_BIT 3
`define IRM_PRI_OE_BIT 4
`define IRM_ALT_OE_BIT 5
`define IRM_EDGE_HI_BIT 7
`define IRM_EDGE_LO_BIT 6

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define IRM_IR_CTRL_RST 3'h0
`define IRM_TMR_CTRL_RST 8'h00
`define IRM_BYTE_RST 8'h00
`define IRM_TICK_DIV 8'h01

`endif

// [shared/irm_pkg.sv]
package irm_pkg;

  typedef logic [7:0] irm_byte_t;

  // Operating mode of the timer pair
  typedef enum logic [1:0] {IRM_TIMER, IRM_IR_RX, IRM_IR_TX} irm_mode_e;

  // Edge selection: 00 none, 01 rising, 10 falling, 11 both
  function automatic logic irm_edge_sel(input logic [1:0] sel, input logic rise, input logic fall);
    irm_edge_sel = (sel[0] & rise) | (sel[1] & fall);
  endfunction : irm_edge_sel

endpackage : irm_pkg

// [shared/irm_edge_if.sv]
`timescale 1ns/1ps
// Filtered pin level with one-cycle edge pulses
interface irm_edge_if;
  logic lvl;
  logic rise;
  logic fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface : irm_edge_if

// [rtl/irm_pin_sync.sv]
`timescale 1ns/1ps
module irm_pin_sync (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic pin,
  irm_edge_if.src e
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic rise_q;
  logic fall_q;
  wire agree = (s2_q == s3_q);
  wire change = agree & (s3_q != lvl_q);

  // Three-stage synchroniser; first stage feeds only the second
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accepted level moves only when stages two and three agree
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lvl_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      lvl_q <= change ? s3_q : lvl_q;
      rise_q <= change & s3_q;
      fall_q <= change & ~s3_q;
    end
  end

  assign e.lvl = lvl_q;
  assign e.rise = rise_q;
  assign e.fall = fall_q;

endmodule : irm_pin_sync

// [rtl/irm_ir_subcarrier_modulator.sv]
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "irm_regs.svh"

module irm_ir_subcarrier_modulator
  import irm_pkg::*;
#(
  parameter logic [7:0] TICK_DIV = `IRM_TICK_DIV
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic primary_timer_pin_in,
  output logic primary_timer_pin_out,
  output logic primary_timer_pin_oe,
  input wire logic external_count_pin,
  output logic alternate_timer_pin_out,
  output logic alternate_timer_pin_oe
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic ir_mode_enable_q;
  logic ir_transmit_select_q;
  logic ir_bit_control_q;
  logic ir_bit_control_d;
  irm_byte_t tmr_ctrl_q;
  irm_byte_t lo_reload_q;
  irm_byte_t lo_cmp_q;
  irm_byte_t high_reload_value_q;
  irm_byte_t high_match_value_q;
  irm_byte_t low_byte_timer_q;
  irm_byte_t low_byte_timer_d;
  irm_byte_t high_byte_counter_q;
  irm_byte_t high_byte_counter_d;
  irm_byte_t tick_cnt_q;
  logic gate_q;
  logic gate_d;
  logic carrier_q;
  logic carrier_prev_q;
  logic pri_tog_q;
  logic alt_out_d;
  logic alt_oe_d;
  irm_mode_e mode;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  irm_edge_if rx_e ();
  irm_edge_if ext_e ();

  // Receive pin passes four flops before use
  irm_pin_sync u_rx_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .pin(primary_timer_pin_in),
    .e(rx_e)
  );

  // External count pin for the plain counter mode
  irm_pin_sync u_ext_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .pin(external_count_pin),
    .e(ext_e)
  );

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire req = avs_read | avs_write;
  wire wr_acc = avs_write & ~avs_waitrequest;
  wire wr_ir = wr_acc & (avs_address == `IRM_OFS_IR_CTRL);
  wire wr_tmr = wr_acc & (avs_address == `IRM_OFS_TMR_CTRL);
  wire wr_lrl = wr_acc & (avs_address == `IRM_OFS_LO_RELOAD);
  wire wr_lcm = wr_acc & (avs_address == `IRM_OFS_LO_CMP);
  wire wr_lval = wr_acc & (avs_address == `IRM_OFS_LO_VAL);
  wire wr_hval = wr_acc & (avs_address == `IRM_OFS_HI_VAL);
  wire wr_hrl = wr_acc & (avs_address == `IRM_OFS_HI_RELOAD);
  wire wr_hm = wr_acc & (avs_address == `IRM_OFS_HI_MATCH);
  wire [7:0] wbyte = avs_writedata[7:0];

  // Control fields
  wire dual_byte_select = tmr_ctrl_q[`IRM_DUAL_BIT];
  wire lo_run = tmr_ctrl_q[`IRM_LO_RUN_BIT];
  wire hi_run = tmr_ctrl_q[`IRM_HI_RUN_BIT];
  wire alt_output_polarity = tmr_ctrl_q[`IRM_POL_BIT];
  wire primary_output_enable = tmr_ctrl_q[`IRM_PRI_OE_BIT];
  wire alt_output_enable = tmr_ctrl_q[`IRM_ALT_OE_BIT];
  wire [1:0] edge_select_field = tmr_ctrl_q[`IRM_EDGE_HI_BIT:`IRM_EDGE_LO_BIT];

  // Read mux; reserved and unmapped read as zero
  wire [7:0] ir_rd = {5'h00, ir_mode_enable_q, ir_transmit_select_q, ir_bit_control_q};
  wire [7:0] rd_byte =
    (avs_address == `IRM_OFS_IR_CTRL) ? ir_rd :
    (avs_address == `IRM_OFS_TMR_CTRL) ? tmr_ctrl_q :
    (avs_address == `IRM_OFS_LO_RELOAD) ? lo_reload_q :
    (avs_address == `IRM_OFS_LO_CMP) ? lo_cmp_q :
    (avs_address == `IRM_OFS_LO_VAL) ? low_byte_timer_q :
    (avs_address == `IRM_OFS_HI_VAL) ? high_byte_counter_q :
    (avs_address == `IRM_OFS_HI_RELOAD) ? high_reload_value_q :
    (avs_address == `IRM_OFS_HI_MATCH) ? high_match_value_q : 8'h00;

  // ----------------------------------------
  // Mode selection
  // ----------------------------------------
  // Transmit select only matters with IR mode enabled
  assign mode = (!ir_mode_enable_q || !dual_byte_select) ? IRM_TIMER :
                ir_transmit_select_q ? IRM_IR_TX : IRM_IR_RX;
  wire ir_on = (mode != IRM_TIMER);
  wire rx_mode = (mode == IRM_IR_RX);
  wire tx_mode = (mode == IRM_IR_TX);

  // ----------------------------------------
  // Timer tick and low timer
  // ----------------------------------------
  wire tick = (tick_cnt_q == TICK_DIV - 8'h01);
  wire lo_ovf = lo_run & tick & (low_byte_timer_q == 8'hff);
  wire [15:0] val16 = {high_byte_counter_q, low_byte_timer_q};
  wire [15:0] cmp16 = {high_match_value_q, lo_cmp_q};

  // Subcarrier leaves idle level at compare, returns at reload
  wire cmp_past = dual_byte_select ? (low_byte_timer_q >= lo_cmp_q) : (val16 >= cmp16);
  wire carrier_d = alt_output_polarity ^ (lo_run & cmp_past);

  // Counted subcarrier edge: rising if idle high, else falling
  wire car_rise = carrier_q & ~carrier_prev_q;
  wire car_fall = ~carrier_q & carrier_prev_q;
  wire car_edge = alt_output_polarity ? car_rise : car_fall;

  // ----------------------------------------
  // High counter events
  // ----------------------------------------
  // IR mode feeds subcarrier edges instead of the external pin
  wire ext_edge = irm_edge_sel(edge_select_field, ext_e.rise, ext_e.fall);
  wire dual_step = hi_run & (ir_on ? car_edge : ext_edge);
  wire hi_step = dual_byte_select ? dual_step : lo_ovf;
  wire hi_ovf = hi_step & (high_byte_counter_q == 8'hff);
  wire [7:0] hi_inc = high_byte_counter_q + 8'h01;
  wire hi_match = hi_step & ~hi_ovf & (hi_inc == high_match_value_q);

  // Receive-pin events only exist in receive mode
  wire rx_resync = rx_mode & irm_edge_sel(edge_select_field, rx_e.rise, rx_e.fall);
  wire rx_latch = rx_mode & hi_match;

  // Low timer next value; in 16-bit mode it wraps except on full overflow
  always_comb begin
    low_byte_timer_d = low_byte_timer_q;
    if (wr_lval) begin
      low_byte_timer_d = wbyte;
    end else if (lo_ovf) begin
      if (!dual_byte_select && !hi_ovf) begin
        low_byte_timer_d = 8'h00;
      end else begin
        low_byte_timer_d = lo_reload_q;
      end
    end else if (lo_run && tick) begin
      low_byte_timer_d = low_byte_timer_q + 8'h01;
    end
  end

  // High counter next value
  always_comb begin
    high_byte_counter_d = high_byte_counter_q;
    if (wr_hval) begin
      high_byte_counter_d = wbyte;
    end else if (rx_resync) begin
      high_byte_counter_d = high_reload_value_q;
    end else if (hi_ovf) begin
      high_byte_counter_d = high_reload_value_q;
    end else if (hi_step) begin
      high_byte_counter_d = hi_inc;
    end
  end

  // Bit-control flag: hardware capture wins over a software write
  always_comb begin
    ir_bit_control_d = ir_bit_control_q;
    if (rx_latch) begin
      ir_bit_control_d = rx_e.lvl;
    end else if (wr_ir) begin
      ir_bit_control_d = wbyte[`IRM_IR_BB_BIT];
    end
  end

  // Transmit gate follows the flag only at high overflow
  always_comb begin
    gate_d = gate_q;
    if (!tx_mode) begin
      gate_d = 1'b0;
    end else if (hi_ovf) begin
      gate_d = ir_bit_control_q;
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // Transmit mode owns the alternate pin with polarity idle level
  always_comb begin
    case (mode)
      IRM_IR_TX: begin
        alt_oe_d = 1'b1;
        alt_out_d = gate_q ? carrier_q : alt_output_polarity;
      end
      IRM_IR_RX, IRM_TIMER: begin
        alt_oe_d = alt_output_enable;
        alt_out_d = carrier_q;
      end
      default: begin
        alt_oe_d = 1'b0;
        alt_out_d = alt_output_polarity;
      end
    endcase
  end

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // One wait cycle, then accept; read data loaded in the wait cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= {24'h000000, rd_byte};
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  // Control register: bits 2..0 writable, rest reserved
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {ir_mode_enable_q, ir_transmit_select_q, ir_bit_control_q} <= `IRM_IR_CTRL_RST;
    end else begin
      if (wr_ir) begin
        ir_mode_enable_q <= wbyte[`IRM_IR_EN_BIT];
        ir_transmit_select_q <= wbyte[`IRM_IR_TX_BIT];
      end
      ir_bit_control_q <= ir_bit_control_d;
    end
  end

  // Timer settings
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tmr_ctrl_q <= `IRM_TMR_CTRL_RST;
      lo_reload_q <= `IRM_BYTE_RST;
      lo_cmp_q <= `IRM_BYTE_RST;
      high_reload_value_q <= `IRM_BYTE_RST;
      high_match_value_q <= `IRM_BYTE_RST;
    end else begin
      tmr_ctrl_q <= wr_tmr ? wbyte : tmr_ctrl_q;
      lo_reload_q <= wr_lrl ? wbyte : lo_reload_q;
      lo_cmp_q <= wr_lcm ? wbyte : lo_cmp_q;
      high_reload_value_q <= wr_hrl ? wbyte : high_reload_value_q;
      high_match_value_q <= wr_hm ? wbyte : high_match_value_q;
    end
  end

  // ----------------------------------------
  // Counters and carrier
  // ----------------------------------------
  // Tick divider and counters
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_q <= 8'h00;
      low_byte_timer_q <= `IRM_BYTE_RST;
      high_byte_counter_q <= `IRM_BYTE_RST;
    end else begin
      tick_cnt_q <= tick ? 8'h00 : tick_cnt_q + 8'h01;
      low_byte_timer_q <= low_byte_timer_d;
      high_byte_counter_q <= high_byte_counter_d;
    end
  end

  // Subcarrier, its delayed copy, and transmit gate
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      carrier_q <= 1'b0;
      carrier_prev_q <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      carrier_q <= carrier_d;
      carrier_prev_q <= carrier_q;
      gate_q <= gate_d;
    end
  end

  // Registered pin outputs
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pri_tog_q <= 1'b0;
      primary_timer_pin_out <= 1'b0;
      primary_timer_pin_oe <= 1'b0;
      alternate_timer_pin_out <= 1'b0;
      alternate_timer_pin_oe <= 1'b0;
    end else begin
      pri_tog_q <= hi_ovf ? ~pri_tog_q : pri_tog_q;
      primary_timer_pin_out <= pri_tog_q;
      primary_timer_pin_oe <= primary_output_enable;
      alternate_timer_pin_out <= alt_out_d;
      alternate_timer_pin_oe <= alt_oe_d;
    end
  end

endmodule : irm_ir_subcarrier_modulator

// [bench/irm_ir_link_model.sv]
`timescale 1ns/1ps
// ----
// IR receiver and emitter stand-in
// ----
module irm_ir_link_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic carrier_on,
  input wire logic emit_pin,
  input wire logic emit_oe,
  input wire logic clr,
  output logic rx_pin,
  output int lit_cnt
);
  // Filtered carrier presence, one cycle late
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_pin <= 1'b0;
    end else begin
      rx_pin <= carrier_on;
    end
  end
  // Cycles the driven emitter pin sits low
  always_ff @(posedge core_clk) begin
    if (clr) begin
      lit_cnt <= 0;
    end else if (emit_oe && !emit_pin) begin
      lit_cnt <= lit_cnt + 1;
    end
  end
endmodule : irm_ir_link_model

// [bench/irm_ir_subcarrier_modulator_properties.sv]
`timescale 1ns/1ps
`include "irm_regs.svh"
module irm_ir_subcarrier_modulator_properties #(
  parameter logic [7:0] TICK_DIV = 8'h01
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic primary_timer_pin_in,
  input wire logic primary_timer_pin_out,
  input wire logic primary_timer_pin_oe,
  input wire logic external_count_pin,
  input wire logic alternate_timer_pin_out,
  input wire logic alternate_timer_pin_oe
);
  // ----
  // Register shadows
  // ----
  logic [7:0] ir_q;
  logic [7:0] tm_q;
  logic [2:0] idle_q;
  logic [2:0] idle_d;
  wire wr_ok = avs_write && !avs_waitrequest;
  wire tm_wr = wr_ok && avs_address == `IRM_OFS_TMR_CTRL;
  wire tx_on = ir_q[`IRM_IR_EN_BIT] && ir_q[`IRM_IR_TX_BIT] && tm_q[`IRM_DUAL_BIT];
  wire bb_on = ir_q[`IRM_IR_BB_BIT];
  wire alt_en = tm_q[`IRM_ALT_OE_BIT];
  // Idle age in transmit; 7 once the flag has been set
  assign idle_d = !tx_on ? 3'h0 : (bb_on || idle_q == 3'h7) ? 3'h7 : tm_wr ? 3'h0 :
                  (idle_q == 3'h4 ? idle_q : idle_q + 3'h1);
  // Shadows update on accepted writes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ir_q <= 8'h00;
      tm_q <= 8'h00;
      idle_q <= 3'h0;
    end else begin
      if (wr_ok && avs_address == `IRM_OFS_IR_CTRL) ir_q <= avs_writedata[7:0];
      if (tm_wr) tm_q <= avs_writedata[7:0];
      idle_q <= idle_d;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  chk_req_answered: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered one cycle later");
  chk_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_no_idle_ack: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("acknowledge without request");
  chk_rd_reserved: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_tx_drives: assert property (tx_on [*3] |-> alternate_timer_pin_oe)
    else $error("transmit pin not driven in transmit mode");
  chk_tx_ignored: assert property ((!tx_on && !alt_en) [*3] |-> !alternate_timer_pin_oe)
    else $error("transmit pin driven outside transmit mode");
  chk_pri_oe_copy: assert property ($stable(tm_q) [*3] |-> primary_timer_pin_oe == tm_q[`IRM_PRI_OE_BIT])
    else $error("primary output enable differs from its bit");
  chk_idle_level: assert property (idle_q == 3'h4 |-> alternate_timer_pin_out == tm_q[`IRM_POL_BIT])
    else $error("transmit pin not at idle level");
endmodule : irm_ir_subcarrier_modulator_properties

bind irm_ir_subcarrier_modulator irm_ir_subcarrier_modulator_properties #(.TICK_DIV(TICK_DIV)) i_chk (
  .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .primary_timer_pin_in(primary_timer_pin_in),
  .primary_timer_pin_out(primary_timer_pin_out), .primary_timer_pin_oe(primary_timer_pin_oe),
  .external_count_pin(external_count_pin), .alternate_timer_pin_out(alternate_timer_pin_out),
  .alternate_timer_pin_oe(alternate_timer_pin_oe));

// [bench/irm_ir_subcarrier_modulator_tb.sv]
`timescale 1ns/1ps
module irm_ir_subcarrier_modulator_tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rx_pin;
  logic alt_out;
  logic alt_oe;
  logic carrier_on = 1'b0;
  logic clr = 1'b0;
  logic [31:0] rdq;
  logic pri_out;
  logic pri_was;
  logic [2:0] ext_div = 3'h0;
  int lit_cnt;
  int n_mismatch = 0;
  int checked = 0;
  // ----
  // Clock, device and far side
  // ----
  always #20 core_clk = ~core_clk;
  // External count pin toggles every four cycles, changed at the rising edge
  always @(posedge core_clk) begin
    ext_div <= ext_div + 3'h1;
  end
  irm_ir_subcarrier_modulator #(.TICK_DIV(8'h01)) i_irm_ir_subcarrier_modulator (
    .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .primary_timer_pin_in(rx_pin), .primary_timer_pin_out(pri_out),
    .primary_timer_pin_oe(), .external_count_pin(ext_div[2]), .alternate_timer_pin_out(alt_out),
    .alternate_timer_pin_oe(alt_oe));
  irm_ir_link_model i_irm_ir_link_model (
    .core_clk(core_clk), .rstn(rstn), .carrier_on(carrier_on), .emit_pin(alt_out),
    .emit_oe(alt_oe), .clr(clr), .rx_pin(rx_pin), .lit_cnt(lit_cnt));
  // ----
  // Tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      n_mismatch++;
      report_and_stop();
    end
    rdq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic put_reg(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : put_reg
  task automatic chk_reg(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rdq, e);
  endtask : chk_reg
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // Clear the lit counter, then let n cycles be counted
  task automatic window(input int n);
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    tick(n);
    @(negedge core_clk);
  endtask : window
  // ----
  // Main sequence
  // ----
  initial begin
    tick(2);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      chk_reg(5'(i * 4), 32'h0);
    end
    put_reg(5'h00, 32'hff);
    chk_reg(5'h00, 32'h07);
    put_reg(5'h04, 32'h0e);
    put_reg(5'h00, 32'h06);
    tick(5);
    check({31'h0, alt_oe}, 32'h0);
    put_reg(5'h00, 32'h02);
    put_reg(5'h04, 32'hcf);
    tick(5);
    check({31'h0, alt_oe}, 32'h0);
    put_reg(5'h08, 32'hfc);
    put_reg(5'h0c, 32'hfe);
    put_reg(5'h18, 32'hfd);
    put_reg(5'h00, 32'h06);
    window(40);
    check(32'(lit_cnt), 32'h0);
    check({31'h0, alt_oe}, 32'h1);
    put_reg(5'h18, 32'h00);
    put_reg(5'h14, 32'h00);
    put_reg(5'h00, 32'h07);
    window(100);
    check(32'(lit_cnt), 32'h0);
    put_reg(5'h18, 32'hfd);
    tick(1100);
    window(64);
    check(32'(lit_cnt), 32'h20);
    // Overflow every three subcarrier edges; external pin edges must not step it
    pri_was = pri_out;
    tick(12);
    @(negedge core_clk);
    check({31'h0, pri_out}, {31'h0, ~pri_was});
    bus(1'b0, 5'h14, 32'h0);
    check({31'h0, rdq[7:0] >= 8'hfd}, 32'h1);
    put_reg(5'h00, 32'h00);
    put_reg(5'h04, 32'h07);
    put_reg(5'h00, 32'h06);
    tick(4);
    window(40);
    check(32'(lit_cnt), 32'h28);
    put_reg(5'h00, 32'h00);
    put_reg(5'h04, 32'h0f);
    put_reg(5'h1c, 32'hfe);
    put_reg(5'h00, 32'h04);
    carrier_on <= 1'b1;
    tick(40);
    chk_reg(5'h00, 32'h05);
    carrier_on <= 1'b0;
    tick(40);
    chk_reg(5'h00, 32'h04);
    put_reg(5'h00, 32'h06);
    carrier_on <= 1'b1;
    tick(40);
    chk_reg(5'h00, 32'h06);
    put_reg(5'h00, 32'h00);
    carrier_on <= 1'b0;
    put_reg(5'h04, 32'h4f);
    put_reg(5'h18, 32'h00);
    put_reg(5'h1c, 32'h10);
    put_reg(5'h14, 32'h80);
    put_reg(5'h00, 32'h04);
    carrier_on <= 1'b1;
    tick(120);
    chk_reg(5'h00, 32'h05);
    report_and_stop();
  end
endmodule : irm_ir_subcarrier_modulator_tb
